// ==== inc/hiq_pkg.sv ====
// constants and types for the identity query / reply exchange
// assumes byte-wide message streams with the tag sent most significant byte first
package hiq_pkg;

  // message tags
  localparam logic [23:0] QUERY_TAG      = 24'h9f9c00;
  localparam logic [23:0] REPLY_TAG      = 24'h9f9c01;

  // length field encoding
  localparam logic [7:0]  LEN_LONG_ONE   = 8'h81;
  localparam logic [7:0]  LEN_SHORT_MAX  = 8'h7f;
  localparam logic [1:0]  LEN_EXT_MAX    = 2'h2;

  // reply layout
  localparam logic [7:0]  FIXED_PAYLOAD  = 8'h08;
  localparam logic [7:0]  DESC_HDR_LEN   = 8'h02;
  localparam logic [7:0]  PRIVATE_TAG    = 8'h00;
  localparam logic [7:0]  PRIVATE_MAX    = 8'h80;
  localparam int          PRIVATE_DEPTH  = 128;
  localparam int          PRIVATE_AW     = 7;
  localparam int          HDR_BYTES      = 15;
  localparam logic [3:0]  HDR_LONG_LAST  = 4'he;
  localparam logic [3:0]  LEN_BYTE_POS   = 4'h3;
  localparam logic [3:0]  DESC_HDR_BYTES = 4'h2;

  // identity defaults, values arbitrary
  localparam logic [23:0] DEFAULT_OUI    = 24'h5a3c91;
  localparam logic [31:0] DEFAULT_HW     = 32'h0000_0a11;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_HDR  = 2'b01,
    TX_DATA = 2'b10
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_TAG0 = 3'b000,
    RX_TAG1 = 3'b001,
    RX_TAG2 = 3'b010,
    RX_LEN  = 3'b011,
    RX_LENX = 3'b100,
    RX_BODY = 3'b101
  } rx_state_t;

endpackage

// ==== inc/query_evt_if.sv ====
// events from the incoming message parser to the reply framer
// assumes one clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface query_evt_if;
  logic query;
  logic length_err;
  logic foreign;
  logic malformed;

  modport src (output query, output length_err, output foreign, output malformed);
  modport snk (input query, input length_err, input foreign, input malformed);
endinterface
`default_nettype wire

// ==== rtl/query_parser.sv ====
// parser of incoming messages: finds identity queries, skips others by length, drops back to the tag after a bad length field
// assumes rx bytes arrive back to back or spaced, one per valid cycle
`timescale 1ns/1ns
`default_nettype none
module query_parser (
  input  wire logic       core_clk_i,  // system clock
  input  wire logic       reset_n_i,   // async reset, active low
  input  wire logic       rx_valid_i,  // byte present
  input  wire logic [7:0] rx_data_i,   // byte value
  query_evt_if.src        evt          // parsed events
);
  hiq_pkg::rx_state_t state;
  logic [15:0] tag_hi;
  logic [7:0]  tag_lo;
  logic [15:0] body_left;
  logic [1:0]  ext_left;
  logic        body_seen;

  wire        is_query  = {tag_hi, tag_lo} == hiq_pkg::QUERY_TAG;
  wire [15:0] ext_len   = {body_left[7:0], rx_data_i};
  wire        short_len = ~rx_data_i[7];
  wire        bad_ext   = rx_data_i[6:0] == 7'h00 ||
                          rx_data_i[6:0] > {5'h00, hiq_pkg::LEN_EXT_MAX};
  wire        fin_len   = state == hiq_pkg::RX_LEN && short_len && rx_data_i == 8'h00;
  wire        fin_ext   = state == hiq_pkg::RX_LENX && ext_left == 2'h1 && ext_len == 16'h0000;
  wire        fin_body  = state == hiq_pkg::RX_BODY && body_left == 16'h0001;
  wire        finish    = rx_valid_i & (fin_len | fin_ext | fin_body);
  wire        malformed = rx_valid_i & state == hiq_pkg::RX_LEN & ~short_len & bad_ext;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      evt.query      <= 1'b0;
      evt.length_err <= 1'b0;
      evt.foreign    <= 1'b0;
      evt.malformed  <= 1'b0;
    end else begin
      evt.query      <= finish & is_query;
      evt.length_err <= finish & is_query & (body_seen | fin_body);
      evt.foreign    <= finish & ~is_query;
      evt.malformed  <= malformed;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state     <= hiq_pkg::RX_TAG0;
      tag_hi    <= 16'h0000;
      tag_lo    <= 8'h00;
      body_left <= 16'h0000;
      ext_left  <= 2'h0;
      body_seen <= 1'b0;
    end else if (rx_valid_i) begin
      unique case (state)
        hiq_pkg::RX_TAG0: begin
          tag_hi[15:8] <= rx_data_i;
          body_seen    <= 1'b0;
          state        <= hiq_pkg::RX_TAG1;
        end
        hiq_pkg::RX_TAG1: begin
          tag_hi[7:0] <= rx_data_i;
          state       <= hiq_pkg::RX_TAG2;
        end
        hiq_pkg::RX_TAG2: begin
          tag_lo <= rx_data_i;
          state  <= hiq_pkg::RX_LEN;
        end
        hiq_pkg::RX_LEN: begin
          if (short_len) begin
            body_left <= {8'h00, rx_data_i};
            body_seen <= rx_data_i != 8'h00;
            state     <= (rx_data_i == 8'h00) ? hiq_pkg::RX_TAG0 : hiq_pkg::RX_BODY;
          end else if (bad_ext) begin
            state <= hiq_pkg::RX_TAG0;
          end else begin
            body_left <= 16'h0000;
            ext_left  <= rx_data_i[1:0];
            state     <= hiq_pkg::RX_LENX;
          end
        end
        hiq_pkg::RX_LENX: begin
          body_left <= ext_len;
          ext_left  <= ext_left - 2'h1;
          if (ext_left == 2'h1) begin
            body_seen <= ext_len != 16'h0000;
            state     <= (ext_len == 16'h0000) ? hiq_pkg::RX_TAG0 : hiq_pkg::RX_BODY;
          end
        end
        hiq_pkg::RX_BODY: begin
          body_left <= body_left - 16'h0001;
          if (body_left == 16'h0001) begin
            state <= hiq_pkg::RX_TAG0;
          end
        end
        default: state <= hiq_pkg::RX_TAG0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== rtl/host_identity_query_exchange.sv ====
// receiver end of the identity query exchange: parses queries, aborts downloads,
// frames and sends the identity reply with an optional private descriptor
// assumes the card side keeps its session open and sends whole messages
`timescale 1ns/1ns
`default_nettype none
module host_identity_query_exchange #(
  parameter logic [23:0] MAKER_OUI_CODE = hiq_pkg::DEFAULT_OUI, // vendor code
  parameter logic [31:0] MODEL_HW_CODE  = hiq_pkg::DEFAULT_HW   // one code per model
) (
  input  wire logic       core_clk_i,        // system clock
  input  wire logic       reset_n_i,         // async reset, active low
  input  wire logic       rx_valid_i,        // incoming byte present
  input  wire logic [7:0] rx_data_i,         // incoming byte
  output logic            tx_valid_o,        // outgoing byte present
  output logic [7:0]      tx_data_o,         // outgoing byte
  output logic            tx_last_o,         // last byte of reply
  input  wire logic       tx_ready_i,        // sink takes byte
  input  wire logic       download_active_i, // code download running
  output logic            download_abort_o,  // abort pulse
  input  wire logic       private_wr_en_i,   // private payload write
  input  wire logic [6:0] private_wr_addr_i, // private payload index
  input  wire logic [7:0] private_wr_data_i, // private payload byte
  input  wire logic       private_len_set_i, // load private length
  input  wire logic [7:0] private_len_i,     // private length, 0 none
  output logic            private_len_err_o, // length refused pulse
  output logic            busy_o,            // reply pending or sending
  output logic            identity_fault_o,  // vendor code invalid
  output logic            query_len_err_o,   // query carried payload pulse
  output logic            foreign_apdu_o,    // other message skipped pulse
  output logic            malformed_o,       // bad length field pulse
  output logic [7:0]      reply_count_o      // replies sent
);
  query_evt_if evt ();

  query_parser u_parser (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .rx_valid_i (rx_valid_i),
    .rx_data_i  (rx_data_i),
    .evt        (evt)
  );

  logic [7:0]  private_mem [hiq_pkg::PRIVATE_DEPTH];
  logic [23:0] maker_oui_code;
  logic [31:0] model_hw_code;
  logic [7:0]  private_len;
  logic [7:0]  snap_len;
  logic        pending;
  logic [3:0]  hdr_idx;
  logic [6:0]  data_idx;
  hiq_pkg::tx_state_t state;

  function automatic logic [7:0] pick_byte(input logic [8*hiq_pkg::HDR_BYTES-1:0] vec,
                                           input logic [3:0] idx);
    pick_byte = vec[8*hiq_pkg::HDR_BYTES-1 - 8*idx -: 8];
  endfunction

  // reply layout derived from the length snapshot
  wire        has_desc      = snap_len != 8'h00;
  wire [7:0]  extension_count = {7'h00, has_desc};
  wire [7:0]  desc_bytes    = has_desc ? hiq_pkg::DESC_HDR_LEN + snap_len : 8'h00;
  wire [7:0]  payload_len   = hiq_pkg::FIXED_PAYLOAD + desc_bytes;
  wire        long_form     = payload_len > hiq_pkg::LEN_SHORT_MAX;
  wire [3:0]  hdr_last      = hiq_pkg::HDR_LONG_LAST - {3'h0, ~long_form} -
                              (has_desc ? 4'h0 : hiq_pkg::DESC_HDR_BYTES);
  wire [3:0]  eff_idx       = (!long_form && hdr_idx >= hiq_pkg::LEN_BYTE_POS) ?
                              hdr_idx + 4'h1 : hdr_idx;
  wire [8*hiq_pkg::HDR_BYTES-1:0] hdr_vec = {
    hiq_pkg::REPLY_TAG,
    hiq_pkg::LEN_LONG_ONE,
    payload_len,
    maker_oui_code,
    model_hw_code,
    extension_count,
    hiq_pkg::PRIVATE_TAG,
    snap_len
  };
  wire [7:0]  hdr_byte      = pick_byte(hdr_vec, eff_idx);
  wire [7:0]  data_byte     = private_mem[data_idx];
  wire        advance       = ~tx_valid_o | tx_ready_i;
  wire        oui_ok        = maker_oui_code != 24'h000000;
  wire        start         = state == hiq_pkg::TX_IDLE && pending && oui_ok && advance;
  wire        hdr_end       = state == hiq_pkg::TX_HDR && advance && hdr_idx == hdr_last;
  wire        data_end      = state == hiq_pkg::TX_DATA && advance &&
                              {1'b0, data_idx} == snap_len - 8'h01;
  wire        reply_done    = (hdr_end && !has_desc) || data_end;
  wire        busy          = pending || state != hiq_pkg::TX_IDLE || tx_valid_o;
  wire        len_ok        = private_len_i <= hiq_pkg::PRIVATE_MAX;
  wire        next_pending  = evt.query | (pending & ~start);

  // identity held in local flops, reported the same in every stream mode
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      maker_oui_code <= MAKER_OUI_CODE;
      model_hw_code  <= MODEL_HW_CODE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (private_wr_en_i && !busy) begin
      private_mem[private_wr_addr_i] <= private_wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      private_len       <= 8'h00;
      private_len_err_o <= 1'b0;
    end else begin
      private_len_err_o <= private_len_set_i & (busy | ~len_ok);
      if (private_len_set_i && !busy && len_ok) begin
        private_len <= private_len_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      download_abort_o <= 1'b0;
      query_len_err_o  <= 1'b0;
      foreign_apdu_o   <= 1'b0;
      malformed_o      <= 1'b0;
      identity_fault_o <= 1'b0;
      busy_o           <= 1'b0;
      pending          <= 1'b0;
    end else begin
      download_abort_o <= evt.query & download_active_i;
      query_len_err_o  <= evt.length_err;
      foreign_apdu_o   <= evt.foreign;
      malformed_o      <= evt.malformed;
      identity_fault_o <= ~oui_ok;
      busy_o           <= busy;
      pending          <= next_pending;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state    <= hiq_pkg::TX_IDLE;
      hdr_idx  <= 4'h0;
      data_idx <= 7'h00;
      snap_len <= 8'h00;
    end else begin
      unique case (state)
        hiq_pkg::TX_IDLE: begin
          if (start) begin
            snap_len <= private_len;
            hdr_idx  <= 4'h0;
            state    <= hiq_pkg::TX_HDR;
          end
        end
        hiq_pkg::TX_HDR: begin
          if (advance) begin
            hdr_idx <= hdr_idx + 4'h1;
            if (hdr_end) begin
              data_idx <= 7'h00;
              state    <= has_desc ? hiq_pkg::TX_DATA : hiq_pkg::TX_IDLE;
            end
          end
        end
        hiq_pkg::TX_DATA: begin
          if (advance) begin
            data_idx <= data_idx + 7'h01;
            if (data_end) begin
              state <= hiq_pkg::TX_IDLE;
            end
          end
        end
        default: state <= hiq_pkg::TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_valid_o    <= 1'b0;
      tx_data_o     <= 8'h00;
      tx_last_o     <= 1'b0;
      reply_count_o <= 8'h00;
    end else if (advance) begin
      tx_valid_o <= state != hiq_pkg::TX_IDLE;
      tx_data_o  <= (state == hiq_pkg::TX_DATA) ? data_byte : hdr_byte;
      tx_last_o  <= reply_done;
      if (reply_done) begin
        reply_count_o <= reply_count_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/host_identity_query_exchange_monitor.sv ====
// concurrent checks on the reply side ports
// bound to the top module from the bench top file
`timescale 1ns/1ns
`default_nettype none
module host_identity_query_exchange_monitor (
  input wire logic       core_clk_i,        // clock
  input wire logic       reset_n_i,         // reset
  input wire logic       tx_valid_o,        // byte valid
  input wire logic [7:0] tx_data_o,         // byte
  input wire logic       tx_last_o,         // last byte
  input wire logic       tx_ready_i,        // sink ready
  input wire logic       download_active_i, // download on
  input wire logic       download_abort_o,  // abort pulse
  input wire logic       private_len_set_i, // length load
  input wire logic [7:0] private_len_i,     // length value
  input wire logic       private_len_err_o, // length refused
  input wire logic       busy_o,            // reply busy
  input wire logic       identity_fault_o,  // bad vendor code
  input wire logic [7:0] reply_count_o      // replies sent
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_TX_HOLD: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
    else $error("reply byte changed while stalled");
  AST_TAG_FIRST: assert property (
    $rose(tx_valid_o) |-> tx_data_o == 8'h9f) else $error("reply tag head wrong");
  AST_TAG_SECOND: assert property (
    $rose(tx_valid_o) && tx_ready_i |=> tx_data_o == 8'h9c) else $error("reply tag mid wrong");
  AST_COUNT_STEP: assert property (
    $rose(tx_last_o) |-> reply_count_o == $past(reply_count_o) + 8'h01)
    else $error("reply count not stepped");
  AST_BUSY_COVERS: assert property (
    tx_valid_o |-> busy_o) else $error("byte sent while idle");
  AST_FAULT_SILENT: assert property (
    identity_fault_o |-> !tx_valid_o) else $error("reply sent with bad vendor code");
  AST_ABORT_CAUSE: assert property (
    download_abort_o |-> $past(download_active_i, 1) || $past(download_active_i, 2)
    || $past(download_active_i, 3)) else $error("abort without download");
  AST_LEN_REFUSE: assert property (
    private_len_set_i && private_len_i > 8'h80 |=> private_len_err_o)
    else $error("oversize private length accepted");
endmodule
`default_nettype wire

// ==== tb/card_model.sv ====
// card side: sends whole messages, collects reply bytes
// assumes one shared clock, driven after rising edges
`timescale 1ns/1ns
`default_nettype none
module card_model (
  input  wire logic       clk,      // clock
  output logic            rx_valid, // byte to host
  output logic [7:0]      rx_data,  // byte value
  output logic            tx_ready, // take reply byte
  input  wire logic       tx_valid, // reply byte valid
  input  wire logic [7:0] tx_data   // reply byte
);
  logic [7:0] got[$];
  logic       slow;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
    slow = 1'b0;
  end
  always @(posedge clk) begin
    tx_ready <= slow ? !tx_ready : 1'b1;
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      rx_valid <= 1'b1;
      rx_data <= b[i];
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    // released line must not look like a held byte
    rx_data <= ~b[b.size() - 1];
  endtask
endmodule
`default_nettype wire

// ==== tb/host_identity_query_exchange_tb_top.sv ====
// self-checking bench for the identity reply block
// card model on the message side, bench drives the host side inputs
`timescale 1ns/1ns
`default_nettype none
module host_identity_query_exchange_tb_top;
  logic clk, rst_n, dl, wen, lset, rxv, txr, txv, last;
  logic [6:0] wad;
  logic [7:0] wd, lval, rxd, txd, cnt;
  logic ab, lerr, qerr, fo, ma, flt;
  int   miscompares, num_checks, n_ab, n_le, n_qe, n_fo, n_ma, reps;
  card_model card (.clk(clk), .rx_valid(rxv), .rx_data(rxd), .tx_ready(txr),
                   .tx_valid(txv), .tx_data(txd));
  host_identity_query_exchange dut (.core_clk_i(clk), .reset_n_i(rst_n), .rx_valid_i(rxv),
    .rx_data_i(rxd), .tx_valid_o(txv), .tx_data_o(txd), .tx_last_o(last), .tx_ready_i(txr),
    .download_active_i(dl), .download_abort_o(ab), .private_wr_en_i(wen),
    .private_wr_addr_i(wad), .private_wr_data_i(wd), .private_len_set_i(lset),
    .private_len_i(lval), .private_len_err_o(lerr), .busy_o(), .identity_fault_o(flt),
    .query_len_err_o(qerr), .foreign_apdu_o(fo), .malformed_o(ma), .reply_count_o(cnt));
  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  always @(posedge clk) begin
    n_ab <= n_ab + int'(ab);
    n_le <= n_le + int'(lerr);
    n_qe <= n_qe + int'(qerr);
    n_fo <= n_fo + int'(fo);
    n_ma <= n_ma + int'(ma);
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic want_reply(int n);
    logic [7:0] e[$];
    int k;
    e = {8'h9f, 8'h9c, 8'h01};
    if (10 + n > 127) e.push_back(8'h81);
    e.push_back(8'(n ? 10 + n : 8));
    for (k = 2; k >= 0; k--) e.push_back(hiq_pkg::DEFAULT_OUI[8*k +: 8]);
    for (k = 3; k >= 0; k--) e.push_back(hiq_pkg::DEFAULT_HW[8*k +: 8]);
    e.push_back(8'(n != 0));
    if (n != 0) begin
      e.push_back(8'h00);
      e.push_back(8'(n));
    end
    for (k = 0; k < n; k++) e.push_back(8'ha0 + 8'(k));
    k = 0;
    while (card.got.size() < e.size() && k < 300) begin
      @(posedge clk);
      k++;
    end
    repeat (6) @(posedge clk);
    check("reply size", card.got.size(), e.size());
    foreach (e[i]) check("reply byte", card.got[i], e[i]);
    card.got.delete();
    reps++;
    check("reply count", cnt, 8'(reps));
  endtask
  task automatic t_plain();
    card.send({8'h9f, 8'h9c, 8'h00, 8'h00});
    want_reply(0);
    $display("test plain done");
  endtask
  task automatic t_abort_skip();
    dl <= 1'b1;
    card.send({8'h9f, 8'h9c, 8'h02, 8'h81, 8'h02, 8'haa, 8'hbb});
    repeat (8) @(posedge clk);
    check("foreign skipped", n_fo, 1);
    check("no abort on other", n_ab, 0);
    card.send({8'h9f, 8'h9c, 8'h00, 8'h01, 8'h77});
    want_reply(0);
    check("abort seen", n_ab, 1);
    check("query length flag", n_qe, 1);
    dl <= 1'b0;
    $display("test abort_skip done");
  endtask
  task automatic t_private();
    int k;
    for (k = 0; k < 3; k++) begin
      wen <= 1'b1;
      wad <= 7'(k);
      wd <= 8'ha0 + 8'(k);
      @(posedge clk);
    end
    wen <= 1'b0;
    lval <= 8'h03;
    lset <= 1'b1;
    @(posedge clk);
    lval <= 8'h81;
    @(posedge clk);
    lval <= 8'h80;
    @(posedge clk);
    lset <= 1'b0;
    repeat (3) @(posedge clk);
    check("length refusals", n_le, 1);
    lval <= 8'h03;
    lset <= 1'b1;
    @(posedge clk);
    lset <= 1'b0;
    card.slow <= 1'b1;
    card.send({8'h9f, 8'h9c, 8'h00, 8'h00});
    want_reply(3);
    card.slow <= 1'b0;
    $display("test private done");
  endtask
  task automatic t_long();
    int k;
    for (k = 0; k < 120; k++) begin
      wen <= 1'b1;
      wad <= 7'(k);
      wd <= 8'ha0 + 8'(k);
      @(posedge clk);
    end
    wen <= 1'b0;
    lval <= 8'h78;
    lset <= 1'b1;
    @(posedge clk);
    lset <= 1'b0;
    card.send({8'h9f, 8'h9c, 8'h05, 8'h83});
    repeat (4) @(posedge clk);
    check("malformed seen", n_ma, 1);
    card.send({8'h9f, 8'h9c, 8'h00, 8'h82, 8'h00, 8'h00});
    repeat (4) @(posedge clk);
    lval <= 8'h10;
    lset <= 1'b1;
    @(posedge clk);
    lset <= 1'b0;
    want_reply(120);
    check("busy refusal", n_le, 2);
    check("identity fault", flt, 1'b0);
    $display("test long done");
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end
  initial begin
    {rst_n, dl, wen, lset, wad, wd, lval} = '0;
    {miscompares, num_checks, n_ab, n_le, n_qe, n_fo, n_ma, reps} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_plain();
    t_abort_skip();
    t_private();
    t_long();
    conclude();
  end
endmodule
bind host_identity_query_exchange host_identity_query_exchange_monitor mon (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .tx_valid_o(tx_valid_o),
  .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i),
  .download_active_i(download_active_i), .download_abort_o(download_abort_o),
  .private_len_set_i(private_len_set_i), .private_len_i(private_len_i),
  .private_len_err_o(private_len_err_o), .busy_o(busy_o),
  .identity_fault_o(identity_fault_o), .reply_count_o(reply_count_o));
`default_nettype wire
